// *** design/sdcke_front.sv ***
// Summary of operation
// - Every address and control input is captured on the rising edge of the true clock.
// - Clock enable high runs clocks, input buffers and drivers; low stops them.
// - Clock enable low with all banks idle gives precharge power-down or self refresh, else active power-down.
// - Self refresh exit is detected on clock enable without a running clock.
// - In power-down all input buffers are off except clocks, termination control and clock enable.
// - In self refresh all input buffers except clock enable are off.
// - A command on an edge with chip select high is ignored.
// - Chip select is a command-code bit and selects one rank among several.
// - The command is decoded from row strobe, column strobe, write enable and chip select together.
// - Termination control is ignored in self refresh and when disabled by mode registers.
module sdcke_front
    import sdcke_pkg::*;
(
    input  wire logic           ref_clk,
    input  wire logic           rst_b,
    input  wire logic           cke,
    input  wire sdcke_cmd_in_t  cmd_in,
    input  wire logic           die_term_ctl,
    input  wire logic           term_mr_en,
    output sdcke_cmd_out_t      cmd_out,
    output sdcke_pwr_t          pwr_state,
    output logic                clk_run,
    output logic                cmd_buf_en,
    output logic                clk_buf_en,
    output logic                out_drv_en,
    output logic                term_on,
    output logic                sref_wake,
    output logic [NUM_BANKS-1:0] bank_open
);

    sdcke_state_t   s_q;
    sdcke_state_t   s_d;
    sdcke_cmd_t     dec;
    logic           sref_exit_async;

    // ------------------------------------------------------------
    // command decode
    // ------------------------------------------------------------
    always_comb begin
        unique case ({cmd_in.ras_b, cmd_in.cas_b, cmd_in.we_b})
            3'b000:  dec = SDCKE_CMD_MRS;
            3'b001:  dec = SDCKE_CMD_REF;
            3'b010:  dec = SDCKE_CMD_PRE;
            3'b011:  dec = SDCKE_CMD_ACT;
            3'b100:  dec = SDCKE_CMD_WR;
            3'b101:  dec = SDCKE_CMD_RD;
            3'b110:  dec = SDCKE_CMD_ZQ;
            default: dec = SDCKE_CMD_NOP;
        endcase
    end

    // self refresh exit seen as a level with no clock needed
    assign sref_exit_async = (s_q.pwr == SDCKE_ST_SREF) && cke;

    // ------------------------------------------------------------
    // next state
    // ------------------------------------------------------------
    always_comb begin
        s_d           = s_q;
        s_d.cmd.valid = 1'b0;
        s_d.cke       = cke;
        case (s_q.pwr)
            SDCKE_ST_ACTIVE: begin
                if (s_q.cke && !cke) begin
                    if (s_q.open != OPEN_RST) begin
                        s_d.pwr = SDCKE_ST_APD;
                    end else if (!cmd_in.cs_b && dec == SDCKE_CMD_REF) begin
                        s_d.pwr = SDCKE_ST_SREF;
                    end else begin
                        s_d.pwr = SDCKE_ST_PPD;
                    end
                end else if (s_q.cke && !cmd_in.cs_b) begin
                    s_d.cmd.valid = (dec != SDCKE_CMD_NOP);
                    s_d.cmd.cmd   = dec;
                    s_d.cmd.bank  = cmd_in.bank;
                    s_d.cmd.addr  = cmd_in.addr;
                    if (dec == SDCKE_CMD_ACT) begin
                        s_d.open[cmd_in.bank] = 1'b1;
                    end else if (dec == SDCKE_CMD_PRE) begin
                        if (cmd_in.addr[10]) begin
                            s_d.open = OPEN_RST;
                        end else begin
                            s_d.open[cmd_in.bank] = 1'b0;
                        end
                    end
                end
            end
            SDCKE_ST_PPD, SDCKE_ST_APD: begin
                if (cke) begin
                    s_d.pwr = SDCKE_ST_ACTIVE;
                end
            end
            SDCKE_ST_SREF: begin
                if (cke) begin
                    s_d.pwr = SDCKE_ST_ACTIVE;
                end
            end
            default: s_d.pwr = SDCKE_ST_ACTIVE;
        endcase
        s_d.term_en = term_mr_en && die_term_ctl && (s_d.pwr != SDCKE_ST_SREF);
    end

    always_ff @(posedge ref_clk) begin
        if (!rst_b) begin
            s_q       <= '0;
            s_q.pwr   <= SDCKE_ST_ACTIVE;
            s_q.cmd.cmd <= SDCKE_CMD_NOP;
            s_q.open  <= OPEN_RST;
        end else begin
            s_q <= s_d;
        end
    end

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    assign cmd_out    = s_q.cmd;
    assign pwr_state  = s_q.pwr;
    assign bank_open  = s_q.open;
    assign clk_run    = (s_q.pwr == SDCKE_ST_ACTIVE);
    assign out_drv_en = (s_q.pwr == SDCKE_ST_ACTIVE);
    assign cmd_buf_en = (s_q.pwr == SDCKE_ST_ACTIVE);
    assign clk_buf_en = (s_q.pwr != SDCKE_ST_SREF);
    assign term_on    = s_q.term_en;
    assign sref_wake  = sref_exit_async;

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    property p_cs_mask;
        @(posedge ref_clk) disable iff (!rst_b)
        (cmd_in.cs_b) |=> !cmd_out.valid;
    endproperty
    a_cs_mask: assert property (p_cs_mask) else $error("command taken with cs high");

    property p_apd;
        @(posedge ref_clk) disable iff (!rst_b)
        (pwr_state == SDCKE_ST_ACTIVE && s_q.cke && !cke && bank_open != OPEN_RST)
            |=> pwr_state == SDCKE_ST_APD;
    endproperty
    a_apd: assert property (p_apd) else $error("active power-down not entered");

    property p_ppd;
        @(posedge ref_clk) disable iff (!rst_b)
        (pwr_state == SDCKE_ST_ACTIVE && s_q.cke && !cke && bank_open == OPEN_RST)
            |=> (pwr_state == SDCKE_ST_PPD || pwr_state == SDCKE_ST_SREF);
    endproperty
    a_ppd: assert property (p_ppd) else $error("idle power-down not entered");

    property p_run;
        @(posedge ref_clk) disable iff (!rst_b)
        clk_run == (pwr_state == SDCKE_ST_ACTIVE) && out_drv_en == clk_run;
    endproperty
    a_run: assert property (p_run) else $error("clocks running outside active");

    property p_pd_buf;
        @(posedge ref_clk) disable iff (!rst_b)
        (pwr_state == SDCKE_ST_PPD || pwr_state == SDCKE_ST_APD) |-> !cmd_buf_en && clk_buf_en;
    endproperty
    a_pd_buf: assert property (p_pd_buf) else $error("power-down buffers wrong");

    property p_sr_buf;
        @(posedge ref_clk) disable iff (!rst_b)
        (pwr_state == SDCKE_ST_SREF) |-> !cmd_buf_en && !clk_buf_en && !term_on;
    endproperty
    a_sr_buf: assert property (p_sr_buf) else $error("self refresh buffers wrong");

    property p_wake;
        @(posedge ref_clk) disable iff (!rst_b)
        (pwr_state == SDCKE_ST_SREF && cke) |-> sref_wake ##1 pwr_state == SDCKE_ST_ACTIVE;
    endproperty
    a_wake: assert property (p_wake) else $error("self refresh exit missed");

    property p_term;
        @(posedge ref_clk) disable iff (!rst_b)
        (!term_mr_en) |=> !term_on;
    endproperty
    a_term: assert property (p_term) else $error("termination on while disabled");

    property p_act;
        @(posedge ref_clk) disable iff (!rst_b)
        (pwr_state == SDCKE_ST_ACTIVE && s_q.cke && cke && !cmd_in.cs_b
            && {cmd_in.ras_b, cmd_in.cas_b, cmd_in.we_b} == 3'b011)
            |=> cmd_out.valid && cmd_out.cmd == SDCKE_CMD_ACT && bank_open[cmd_out.bank];
    endproperty
    a_act: assert property (p_act) else $error("activate not decoded");

    property p_lowpwr_mask;
        @(posedge ref_clk) disable iff (!rst_b)
        (pwr_state != SDCKE_ST_ACTIVE) |=> !cmd_out.valid;
    endproperty
    a_lowpwr_mask: assert property (p_lowpwr_mask) else $error("command taken in low power");

    property p_pre_all;
        @(posedge ref_clk) disable iff (!rst_b)
        (pwr_state == SDCKE_ST_ACTIVE && s_q.cke && cke && !cmd_in.cs_b
            && {cmd_in.ras_b, cmd_in.cas_b, cmd_in.we_b} == 3'b010 && cmd_in.addr[10])
            |=> bank_open == OPEN_RST;
    endproperty
    a_pre_all: assert property (p_pre_all) else $error("precharge all left a bank open");

    property p_sref_entry;
        @(posedge ref_clk) disable iff (!rst_b)
        (pwr_state == SDCKE_ST_ACTIVE && s_q.cke && !cke && !cmd_in.cs_b
            && {cmd_in.ras_b, cmd_in.cas_b, cmd_in.we_b} == 3'b001 && bank_open == OPEN_RST)
            |=> pwr_state == SDCKE_ST_SREF;
    endproperty
    a_sref_entry: assert property (p_sref_entry) else $error("self refresh not entered");

    property p_stay;
        @(posedge ref_clk) disable iff (!rst_b)
        (pwr_state != SDCKE_ST_ACTIVE && !cke) |=> $stable(pwr_state);
    endproperty
    a_stay: assert property (p_stay) else $error("low power left with cke low");

    property p_pd_exit;
        @(posedge ref_clk) disable iff (!rst_b)
        ((pwr_state == SDCKE_ST_PPD || pwr_state == SDCKE_ST_APD) && cke)
            |=> pwr_state == SDCKE_ST_ACTIVE && clk_run;
    endproperty
    a_pd_exit: assert property (p_pd_exit) else $error("power-down exit missed");

    property p_term_on;
        @(posedge ref_clk) disable iff (!rst_b)
        (term_mr_en && die_term_ctl && pwr_state == SDCKE_ST_ACTIVE && !(s_q.cke && !cke))
            |=> term_on;
    endproperty
    a_term_on: assert property (p_term_on) else $error("termination request lost");

endmodule : sdcke_front

// *** design/sdcke_pkg.sv ***
package sdcke_pkg;

    // ------------------------------------------------------------
    // timing
    // ------------------------------------------------------------
    localparam int unsigned CLK_PERIOD_PS        = 5000;
    localparam int unsigned REFI_EXT_NS_X10      = 39;
    localparam int unsigned REFRESH_EXT_MS       = 32;
    localparam int unsigned CORE_MIN_PS          = 13125;
    localparam int unsigned CORE_MIN_CYC         =
        (CORE_MIN_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;

    // ------------------------------------------------------------
    // mode register two bit positions
    // ------------------------------------------------------------
    localparam int unsigned AUTO_SELF_REFRESH_BIT = 6;
    localparam int unsigned EXT_SELF_REFRESH_BIT  = 7;

    // ------------------------------------------------------------
    // widths and reset values
    // ------------------------------------------------------------
    localparam int unsigned ADDR_W               = 14;
    localparam int unsigned BANK_W               = 3;
    localparam int unsigned NUM_BANKS            = 8;
    localparam logic [7:0]  OPEN_RST             = 8'h00;

    typedef enum logic [2:0] {
        SDCKE_CMD_MRS,
        SDCKE_CMD_REF,
        SDCKE_CMD_PRE,
        SDCKE_CMD_ACT,
        SDCKE_CMD_WR,
        SDCKE_CMD_RD,
        SDCKE_CMD_ZQ,
        SDCKE_CMD_NOP
    } sdcke_cmd_t;

    typedef enum logic [1:0] {
        SDCKE_ST_ACTIVE,
        SDCKE_ST_PPD,
        SDCKE_ST_APD,
        SDCKE_ST_SREF
    } sdcke_pwr_t;

    typedef struct packed {
        logic              cs_b;
        logic              ras_b;
        logic              cas_b;
        logic              we_b;
        logic [BANK_W-1:0] bank;
        logic [ADDR_W-1:0] addr;
    } sdcke_cmd_in_t;

    typedef struct packed {
        logic              valid;
        sdcke_cmd_t        cmd;
        logic [BANK_W-1:0] bank;
        logic [ADDR_W-1:0] addr;
    } sdcke_cmd_out_t;

    typedef struct packed {
        sdcke_pwr_t         pwr;
        logic               cke;
        logic [NUM_BANKS-1:0] open;
        sdcke_cmd_out_t     cmd;
        logic               term_en;
    } sdcke_state_t;

endpackage : sdcke_pkg

// *** dv/sdcke_host.sv ***
module sdcke_host
    import sdcke_pkg::*;
(
    input  wire logic    ref_clk,
    output sdcke_cmd_in_t cmd_in,
    output logic          cke
);
    timeunit 1ns;
    timeprecision 1ps;

    // ------------------------------------------------------------
    // controller duties kept as fixed figures
    // ------------------------------------------------------------
    localparam int unsigned REFI_HOT_NS    = REFI_EXT_NS_X10 * 100;
    localparam int unsigned REFRESH_HOT_MS = REFRESH_EXT_MS;
    localparam logic [13:0] AUTO_SELF_OP   = 14'h0001 << AUTO_SELF_REFRESH_BIT;
    localparam int unsigned CORE_LIMIT_PS  = CORE_MIN_PS;

    initial begin
        cmd_in = '1;
        cke    = 1'b0;
    end

    // one command word per falling edge, select bit included
    task automatic issue(input sdcke_cmd_in_t c, input logic k);
        @(negedge ref_clk);
        cmd_in = c;
        cke    = k | (c.ras_b & ~c.cas_b & ~c.cs_b);
    endtask : issue

    // mode register two with automatic self refresh
    task automatic set_mode_two();
        issue('{1'b0, 1'b0, 1'b0, 1'b0, 3'h2, AUTO_SELF_OP}, 1'b1);
    endtask : set_mode_two
endmodule : sdcke_host

// *** dv/sdcke_front_tb_top.sv ***
module sdcke_front_tb_top
    import sdcke_pkg::*;
();
    timeunit 1ns;
    timeprecision 1ps;

    logic                 ref_clk, rst_b, die_term_ctl, term_mr_en, cke;
    sdcke_cmd_in_t        cmd_in;
    sdcke_cmd_out_t       cmd_out;
    sdcke_pwr_t           pwr_state;
    logic                 clk_run, cmd_buf_en, clk_buf_en, out_drv_en, term_on, sref_wake;
    logic [NUM_BANKS-1:0] bank_open;
    int                   num_errors = 0;
    int                   checks_done = 0;
    logic [2:0]           r, b;
    logic [13:0]          a;
    logic                 cs;

    sdcke_host host (.ref_clk, .cmd_in, .cke);
    sdcke_front dut (.ref_clk, .rst_b, .cke, .cmd_in, .die_term_ctl, .term_mr_en, .cmd_out,
        .pwr_state, .clk_run, .cmd_buf_en, .clk_buf_en, .out_drv_en, .term_on, .sref_wake,
        .bank_open);

    initial begin
        ref_clk = 1'b0;
        forever #2.5 ref_clk = ~ref_clk;
    end

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            num_errors++;
            $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
        end
    endtask : chk

    function automatic sdcke_cmd_t dec(input logic [2:0] rcw);
        case (rcw)
            3'h0: return SDCKE_CMD_MRS;
            3'h1: return SDCKE_CMD_REF;
            3'h2: return SDCKE_CMD_PRE;
            3'h3: return SDCKE_CMD_ACT;
            3'h4: return SDCKE_CMD_WR;
            3'h5: return SDCKE_CMD_RD;
            3'h6: return SDCKE_CMD_ZQ;
            default: return SDCKE_CMD_NOP;
        endcase
    endfunction : dec

    // drive one command, then look just after the taking edge
    task automatic cmd(input logic [2:0] rcw, input logic [2:0] bk, input logic [13:0] ad,
                       input logic sel_b, input logic k);
        host.issue('{sel_b, rcw[2], rcw[1], rcw[0], bk, ad}, k);
        @(posedge ref_clk);
        #1;
    endtask : cmd

    task automatic wait_pwr(input sdcke_pwr_t p);
        repeat (4) if (pwr_state !== p) begin
            @(posedge ref_clk);
            #1;
        end
        chk(pwr_state, p);
    endtask : wait_pwr

    // enter a low-power state, probe it, wake up
    task automatic pd(input logic [2:0] pre_r, input logic [13:0] pre_a, input logic [2:0] rcw,
                      input sdcke_pwr_t p, input logic [3:0] bufs);
        cmd(pre_r, 3'h5, pre_a, 1'b0, 1'b1);
        cmd(rcw, 3'h0, 14'h0000, 1'b0, 1'b0);
        wait_pwr(p);
        chk({clk_run, cmd_buf_en, clk_buf_en, out_drv_en}, bufs);
        chk(term_on, p != SDCKE_ST_SREF);
        cmd(3'h3, 3'h1, 14'h0000, 1'b0, 1'b0);
        chk(cmd_out.valid, 1'b0);
        host.issue('{1'b1, 1'b1, 1'b0, 1'b0, 3'h6, 14'h1555}, 1'b1);
        #1;
        chk(sref_wake, p == SDCKE_ST_SREF);
        wait_pwr(SDCKE_ST_ACTIVE);
        cmd(3'h7, 3'h0, 14'h0000, 1'b1, 1'b1);
        chk({clk_run, cmd_buf_en, clk_buf_en, out_drv_en}, 4'hf);
    endtask : pd

    task automatic summarize();
        $display("errors %0d checks %0d", num_errors, checks_done);
        if (num_errors == 0 && checks_done > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask : summarize

    initial begin
        #(20000 * 5);
        num_errors++;
        summarize();
    end

    initial begin
        rst_b        = 1'b0;
        die_term_ctl = 1'b1;
        term_mr_en   = 1'b1;
        void'($urandom(42));
        repeat (10) @(negedge ref_clk);
        rst_b = 1'b1;
        cmd(3'h7, 3'h0, 14'h0000, 1'b1, 1'b1);
        host.set_mode_two();
        @(posedge ref_clk);
        #1;
        chk({cmd_out.valid, cmd_out.cmd, cmd_out.bank, cmd_out.addr},
            {1'b1, SDCKE_CMD_MRS, 3'h2, 14'h0040});
        repeat (300) begin
            r  = $urandom;
            b  = $urandom;
            a  = $urandom;
            cs = $urandom;
            @(negedge ref_clk);
            die_term_ctl = $urandom;
            cmd(r, b, a, cs, 1'b1);
            chk(term_on, die_term_ctl);
            chk(cmd_out.valid, !cs && r != 3'h7);
            if (!cs && r != 3'h7) begin
                chk(cmd_out.cmd, dec(r));
                chk({cmd_out.bank, cmd_out.addr}, {b, a});
            end
        end
        @(negedge ref_clk);
        die_term_ctl = 1'b1;
        cmd(3'h2, 3'h0, 14'h0400, 1'b0, 1'b1);
        cmd(3'h3, 3'h5, 14'h0000, 1'b0, 1'b1);
        chk(bank_open, 8'h20);
        pd(3'h3, 14'h0000, 3'h7, SDCKE_ST_APD, 4'h2);
        pd(3'h2, 14'h0400, 3'h7, SDCKE_ST_PPD, 4'h2);
        pd(3'h2, 14'h0400, 3'h1, SDCKE_ST_SREF, 4'h0);
        @(negedge ref_clk);
        term_mr_en = 1'b0;
        cmd(3'h7, 3'h0, 14'h0000, 1'b1, 1'b1);
        cmd(3'h7, 3'h0, 14'h0000, 1'b1, 1'b1);
        chk(term_on, 1'b0);
        summarize();
    end
endmodule : sdcke_front_tb_top
